/* File: pcr_consts.svh */
// offsets, field positions, reset values and timing figures of the protection config bank
// assumes a 25 MHz mclk; included by bare name
`ifndef PCR_CONSTS_SVH
`define PCR_CONSTS_SVH

// ==========================================
// register select codes and reset values
`define PCR_SEL_PROT       1'h0
`define PCR_SEL_TURNOFF    1'h1
`define PCR_PROT_RESET     16'h0934
`define PCR_TURNOFF_RESET  16'h7741

// ==========================================
// first register field positions
`define PCR_F_UV_OFF       15
`define PCR_F_TSD_FLT_HI   14
`define PCR_F_TSD_FLT_LO   13
`define PCR_F_SAT_FLT      12
`define PCR_F_OV_OFF       11
`define PCR_F_MILLER_SRC   10
`define PCR_F_BLANK_HI     9
`define PCR_F_BLANK_LO     8
`define PCR_F_GM_OFF       7
`define PCR_F_MILLER_OFF   6
`define PCR_F_CCLAMP_ON    5
`define PCR_F_SAT_ON       4
`define PCR_F_SC_OFF       3
`define PCR_F_OC_OFF       2
`define PCR_F_TSD_ON       1
`define PCR_F_NEG_ON       0

// ==========================================
// second register field positions
`define PCR_F_GM_SOFT_OFF  15
`define PCR_F_THR_HI       14
`define PCR_F_THR_LO       11
`define PCR_F_CHG_HI       10
`define PCR_F_CHG_LO       9
`define PCR_F_PULLDN       8
`define PCR_F_MTH_HI       7
`define PCR_F_MTH_LO       6
`define PCR_F_STO_HI       5
`define PCR_F_STO_LO       4
`define PCR_F_MODE_HI      3
`define PCR_F_MODE_LO      1
`define PCR_F_MUTE_ON      0
`define PCR_MODE_TWO_LEVEL 2

// ==========================================
// timing: figures in ns, counts rounded up (filter and blank times are minimums)
`define PCR_CLK_NS         40
`define PCR_CYC(ns)        (((ns) + `PCR_CLK_NS - 1) / `PCR_CLK_NS)
`define PCR_TSD_NS0        250
`define PCR_TSD_NS1        500
`define PCR_TSD_NS2        750
`define PCR_TSD_NS3        1000
`define PCR_SAT_NS0        158
`define PCR_SAT_NS1        316
`define PCR_BLK_NS0        500
`define PCR_BLK_NS1        1000
`define PCR_BLK_NS2        2500
`define PCR_BLK_NS3        4000
`define PCR_MUTE_NS        10000

`endif

/* File: pcr_pkg.sv */
// types shared by the protection config bank
// assumes nothing beyond a SystemVerilog compiler
package pcr_pkg;

	// ==========================================
	// field types
	typedef logic [1:0] pcr_code2_t;
	typedef logic [2:0] pcr_mode_t;
	typedef logic [7:0] pcr_span_t;

endpackage

/* File: pcr_deglitch.sv */
// level filter: output rises once the input has been high for span cycles
// assumes input already synchronised to mclk
module pcr_deglitch #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         level,
	input  wire logic [W-1:0] span,
	output logic              hit
);

	logic [W-1:0] count;
	logic [W-1:0] next_count;
	logic         next_hit;

	// ==========================================
	// counter saturates so a long steady level never wraps
	always_comb begin
		next_count = count;
		next_hit   = 1'b0;
		if (!level) begin
			next_count = '0;
		end else if (count < span) begin
			next_count = W'(count + 1'b1);
		end else begin
			next_hit = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			count <= '0;
			hit   <= 1'b0;
		end else begin
			count <= next_count;
			hit   <= next_hit;
		end
	end

endmodule

/* File: pcr_top.sv */
// protection configuration register bank with the filters and fault steering it controls
// assumes the serial config port is decoded upstream into sel/write/data on mclk;
// trip and pwm inputs come from pins and are synchronised here
`include "pcr_consts.svh"

module pcr_top #(
	parameter int MUTE_CYCLES = `PCR_CYC(`PCR_MUTE_NS)
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        cfg_sel,
	input  wire logic        cfg_wr,
	input  wire logic [15:0] cfg_wdata,
	output logic      [15:0] cfg_rdata,
	input  wire logic        thermal_trip_in,
	input  wire logic        saturation_trip_in,
	input  wire logic        short_trip_in,
	input  wire logic        overcurrent_trip_in,
	input  wire logic        gate_fault_in,
	input  wire logic        pwm_in,
	output logic [15:0]      protection_enable_config,
	output logic [15:0]      desat_turnoff_config,
	output logic             thermal_fault,
	output logic             saturation_fault,
	output logic             short_fault,
	output logic             overcurrent_fault,
	output logic             gate_monitor_fault,
	output logic             soft_off_req,
	output logic             two_level_req,
	output logic             pwm_muted,
	output logic             pwm_out
);

	// ==========================================
	// timing lookups
	function automatic pcr_pkg::pcr_span_t tsd_span(input pcr_pkg::pcr_code2_t code);
		case (code)
			2'h0:    tsd_span = 8'(`PCR_CYC(`PCR_TSD_NS0));
			2'h1:    tsd_span = 8'(`PCR_CYC(`PCR_TSD_NS1));
			2'h2:    tsd_span = 8'(`PCR_CYC(`PCR_TSD_NS2));
			default: tsd_span = 8'(`PCR_CYC(`PCR_TSD_NS3));
		endcase
	endfunction

	function automatic pcr_pkg::pcr_span_t blank_span(input pcr_pkg::pcr_code2_t code);
		case (code)
			2'h0:    blank_span = 8'(`PCR_CYC(`PCR_BLK_NS0));
			2'h1:    blank_span = 8'(`PCR_CYC(`PCR_BLK_NS1));
			2'h2:    blank_span = 8'(`PCR_CYC(`PCR_BLK_NS2));
			default: blank_span = 8'(`PCR_CYC(`PCR_BLK_NS3));
		endcase
	endfunction

	// true when the turnoff mode covers a fault of the given reach (1 sc/desat, 2 +oc, 3 +tsd)
	function automatic logic mode_covers(input pcr_pkg::pcr_mode_t mode, input pcr_pkg::pcr_code2_t reach);
		mode_covers = (mode[1:0] != 2'h0) && (mode[1:0] >= reach);
	endfunction

	// ==========================================
	// register file
	logic [15:0] next_prot;
	logic [15:0] next_turnoff;
	logic [15:0] next_rdata;

	always_comb begin
		next_prot    = protection_enable_config;
		next_turnoff = desat_turnoff_config;
		if (cfg_wr && cfg_sel == `PCR_SEL_PROT) begin
			next_prot = cfg_wdata;
		end
		if (cfg_wr && cfg_sel == `PCR_SEL_TURNOFF) begin
			next_turnoff = cfg_wdata;
		end
		// read data follows the selected register one cycle later
		next_rdata = (cfg_sel == `PCR_SEL_PROT) ? protection_enable_config : desat_turnoff_config;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			protection_enable_config <= `PCR_PROT_RESET;
			desat_turnoff_config     <= `PCR_TURNOFF_RESET;
			cfg_rdata                <= 16'h0000;
		end else begin
			protection_enable_config <= next_prot;
			desat_turnoff_config     <= next_turnoff;
			cfg_rdata                <= next_rdata;
		end
	end

	// ==========================================
	// pin synchronisers; stage one read only by stage two
	logic [5:0] sync1;
	logic [5:0] sync2;
	logic       pwm_d;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sync1 <= 6'h00;
			sync2 <= 6'h00;
			pwm_d <= 1'b0;
		end else begin
			sync1 <= {pwm_in, gate_fault_in, overcurrent_trip_in, short_trip_in, saturation_trip_in, thermal_trip_in};
			sync2 <= sync1;
			pwm_d <= sync2[5];
		end
	end

	// ==========================================
	// filters
	logic tsd_hit;
	logic sat_hit;
	logic blank_done;
	logic pwm_edge;

	assign pwm_edge = sync2[5] ^ pwm_d;

	pcr_deglitch #(.W(8)) u_tsd (
		.mclk  (mclk),
		.rst_n (rst_n),
		.level (sync2[0]),
		.span  (tsd_span(protection_enable_config[`PCR_F_TSD_FLT_HI:`PCR_F_TSD_FLT_LO])),
		.hit   (tsd_hit)
	);

	pcr_deglitch #(.W(8)) u_sat (
		.mclk  (mclk),
		.rst_n (rst_n),
		.level (sync2[1]),
		.span  (protection_enable_config[`PCR_F_SAT_FLT] ? 8'(`PCR_CYC(`PCR_SAT_NS1)) : 8'(`PCR_CYC(`PCR_SAT_NS0))),
		.hit   (sat_hit)
	);

	// blanking restarts on every pwm edge; the filter counts quiet cycles since
	pcr_deglitch #(.W(8)) u_blank (
		.mclk  (mclk),
		.rst_n (rst_n),
		.level (!pwm_edge),
		.span  (blank_span(protection_enable_config[`PCR_F_BLANK_HI:`PCR_F_BLANK_LO])),
		.hit   (blank_done)
	);

	// ==========================================
	// fault qualification and turnoff steering
	pcr_pkg::pcr_mode_t mode;
	logic               next_tsd;
	logic               next_sat;
	logic               next_sc;
	logic               next_oc;
	logic               next_gm;
	logic               turnoff_hit;
	logic               next_soft;
	logic               next_two;

	assign mode = desat_turnoff_config[`PCR_F_MODE_HI:`PCR_F_MODE_LO];

	always_comb begin
		next_tsd = tsd_hit && protection_enable_config[`PCR_F_TSD_ON];
		next_sat = sat_hit && protection_enable_config[`PCR_F_SAT_ON];
		next_sc  = sync2[2] && !protection_enable_config[`PCR_F_SC_OFF];
		next_oc  = sync2[3] && !protection_enable_config[`PCR_F_OC_OFF];
		// codes 0 and 4 reach nothing
		turnoff_hit = ((next_sc || next_sat) && mode_covers(mode, 2'h1))
			|| (next_oc && mode_covers(mode, 2'h2))
			|| (next_tsd && mode_covers(mode, 2'h3));
		next_soft = turnoff_hit && !mode[`PCR_MODE_TWO_LEVEL];
		next_two  = turnoff_hit && mode[`PCR_MODE_TWO_LEVEL];
		// monitor may be held off while a turnoff is running
		next_gm = sync2[4] && blank_done && !protection_enable_config[`PCR_F_GM_OFF]
			&& !((soft_off_req || two_level_req) && desat_turnoff_config[`PCR_F_GM_SOFT_OFF]);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			thermal_fault      <= 1'b0;
			saturation_fault   <= 1'b0;
			short_fault        <= 1'b0;
			overcurrent_fault  <= 1'b0;
			gate_monitor_fault <= 1'b0;
			soft_off_req       <= 1'b0;
			two_level_req      <= 1'b0;
		end else begin
			thermal_fault      <= next_tsd;
			saturation_fault   <= next_sat;
			short_fault        <= next_sc;
			overcurrent_fault  <= next_oc;
			gate_monitor_fault <= next_gm;
			soft_off_req       <= next_soft;
			two_level_req      <= next_two;
		end
	end

	// ==========================================
	// pwm mute after short, overcurrent or overtemperature
	logic [15:0] mute_count;
	logic [15:0] next_mute_count;
	logic        mute_trigger;
	logic        next_muted;
	logic        next_pwm;

	always_comb begin
		mute_trigger    = (next_sc || next_oc || next_tsd) && desat_turnoff_config[`PCR_F_MUTE_ON];
		next_mute_count = mute_count;
		if (mute_trigger) begin
			// retriggers while a fault stays present
			next_mute_count = 16'(MUTE_CYCLES);
		end else if (mute_count != 16'h0000) begin
			next_mute_count = 16'(mute_count - 1'b1);
		end
		next_muted = next_mute_count != 16'h0000;
		next_pwm   = sync2[5] && !next_muted;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mute_count <= 16'h0000;
			pwm_muted  <= 1'b0;
			pwm_out    <= 1'b0;
		end else begin
			mute_count <= next_mute_count;
			pwm_muted  <= next_muted;
			pwm_out    <= next_pwm;
		end
	end

	// lockout, clamp and source bits leave on protection_enable_config

endmodule

/* File: pcr_props.sv */
// port assertions for the protection config bank
// assumes binding into pcr_top; one clock, synchronous active-low reset
module pcr_props (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        cfg_sel,
	input wire logic        cfg_wr,
	input wire logic [15:0] cfg_wdata,
	input wire logic [15:0] cfg_rdata,
	input wire logic [15:0] protection_enable_config,
	input wire logic [15:0] desat_turnoff_config,
	input wire logic        short_fault,
	input wire logic        overcurrent_fault,
	input wire logic        thermal_fault,
	input wire logic        soft_off_req,
	input wire logic        two_level_req,
	input wire logic        pwm_muted,
	input wire logic        pwm_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	logic [2:0] mode;
	assign mode = desat_turnoff_config[3:1];
	// ==========================================
	// register writes and readback
	chk_wr_prot: assert property (
		cfg_wr && !cfg_sel |=> protection_enable_config == $past(cfg_wdata))
		else $error("first register write lost");
	chk_wr_turnoff: assert property (
		cfg_wr && cfg_sel |=> desat_turnoff_config == $past(cfg_wdata))
		else $error("second register write lost");
	chk_regs_hold: assert property (
		!cfg_wr |=> $stable(protection_enable_config) && $stable(desat_turnoff_config))
		else $error("register changed without a write");
	// a cycle spent in reset clears the readback instead of copying
	chk_rdata_mux: assert property (
		$past(rst_n) |-> cfg_rdata == ($past(cfg_sel) ? $past(desat_turnoff_config)
			: $past(protection_enable_config)))
		else $error("readback mismatch");
	// ==========================================
	// enables and fault steering
	chk_sc_gate: assert property (
		short_fault |-> !$past(protection_enable_config[3]))
		else $error("short fault while disabled");
	chk_oc_gate: assert property (
		overcurrent_fault |-> !$past(protection_enable_config[2]))
		else $error("overcurrent fault while disabled");
	chk_tsd_gate: assert property (
		thermal_fault |-> $past(protection_enable_config[1]))
		else $error("thermal fault while disabled");
	chk_soft_mode: assert property (
		soft_off_req |-> $past(mode) inside {3'h1, 3'h2, 3'h3})
		else $error("soft turnoff in wrong mode");
	chk_two_mode: assert property (
		two_level_req |-> $past(mode) inside {3'h5, 3'h6, 3'h7})
		else $error("two level turnoff in wrong mode");
	chk_mute_gate: assert property (
		pwm_muted |-> !pwm_out)
		else $error("pwm passed while muted");
	cover property (soft_off_req);
	cover property (two_level_req);
	cover property (pwm_muted);
endmodule

/* File: protection_config_registers_bench.sv */
// self-checking bench for the protection config bank
// assumes pcr_top and pcr_props are compiled first
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module protection_config_registers_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk, rst_n, cfg_sel, cfg_wr, pwm_in, pwm_out, pwm_muted;
	logic        thermal_trip_in, saturation_trip_in, short_trip_in, overcurrent_trip_in, gate_fault_in;
	logic        thermal_fault, saturation_fault, short_fault, overcurrent_fault, gate_monitor_fault;
	logic        soft_off_req, two_level_req;
	logic [15:0] cfg_wdata, cfg_rdata, protection_enable_config, desat_turnoff_config;
	int          failures, cmp_count;
	pcr_top #(.MUTE_CYCLES(10)) dut (
		.mclk                     (mclk),
		.rst_n                    (rst_n),
		.cfg_sel                  (cfg_sel),
		.cfg_wr                   (cfg_wr),
		.cfg_wdata                (cfg_wdata),
		.cfg_rdata                (cfg_rdata),
		.thermal_trip_in          (thermal_trip_in),
		.saturation_trip_in       (saturation_trip_in),
		.short_trip_in            (short_trip_in),
		.overcurrent_trip_in      (overcurrent_trip_in),
		.gate_fault_in            (gate_fault_in),
		.pwm_in                   (pwm_in),
		.protection_enable_config (protection_enable_config),
		.desat_turnoff_config     (desat_turnoff_config),
		.thermal_fault            (thermal_fault),
		.saturation_fault         (saturation_fault),
		.short_fault              (short_fault),
		.overcurrent_fault        (overcurrent_fault),
		.gate_monitor_fault       (gate_monitor_fault),
		.soft_off_req             (soft_off_req),
		.two_level_req            (two_level_req),
		.pwm_muted                (pwm_muted),
		.pwm_out                  (pwm_out)
	);
	initial begin
		mclk = 0;
		forever #20 mclk = ~mclk;
	end
	task final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task wr(input logic s, input logic [15:0] d);
		@(negedge mclk);
		cfg_sel = s;
		cfg_wr = 1;
		cfg_wdata = d;
		@(negedge mclk);
		cfg_wr = 0;
	endtask
	// ==========================================
	// scenarios
	task t_rw();
		wr(1'h0, 16'ha5c3);
		wr(1'h1, 16'h5a3c);
		`CHK("reg1", 16'ha5c3, protection_enable_config)
		`CHK("reg2", 16'h5a3c, desat_turnoff_config)
		cfg_sel = 0;
		repeat (2) @(negedge mclk);
		`CHK("rd1", 16'ha5c3, cfg_rdata)
		cfg_sel = 1;
		repeat (2) @(negedge mclk);
		`CHK("rd2", 16'h5a3c, cfg_rdata)
	endtask
	task t_modes();
		for (int m = 0; m < 8; m++) begin
			wr(1'h0, 16'h0000);
			wr(1'h1, {12'h000, m[2:0], 1'h1});
			short_trip_in = 1;
			repeat (4) @(negedge mclk);
			`CHK("sc", 1'h1, short_fault)
			`CHK("soft", (m > 0 && m < 4), soft_off_req)
			`CHK("two", (m > 4), two_level_req)
			`CHK("mute", 1'h1, pwm_muted)
			`CHK("gated", 1'h0, pwm_out)
			short_trip_in = 0;
			repeat (20) @(negedge mclk);
			`CHK("unmute", 1'h1, pwm_out)
		end
	endtask
	task t_prot();
		// mute armed so a disabled trip that still muted would show
		wr(1'h1, 16'h0001);
		wr(1'h0, 16'h000c);
		short_trip_in = 1;
		overcurrent_trip_in = 1;
		repeat (8) @(negedge mclk);
		`CHK("sc_off", 1'h0, short_fault)
		`CHK("oc_off", 1'h0, overcurrent_fault)
		`CHK("no_mute", 1'h0, pwm_muted)
		// longest thermal filter: 25 cycles plus sync
		wr(1'h0, 16'h6002);
		@(negedge mclk);
		`CHK("sc_on", 1'h1, short_fault)
		`CHK("oc_on", 1'h1, overcurrent_fault)
		thermal_trip_in = 1;
		repeat (20) @(negedge mclk);
		`CHK("th_early", 1'h0, thermal_fault)
		repeat (12) @(negedge mclk);
		`CHK("th_late", 1'h1, thermal_fault)
		{thermal_trip_in, short_trip_in, overcurrent_trip_in} = 3'h0;
		repeat (8) @(negedge mclk);
	endtask
	task t_sat_gm();
		wr(1'h1, 16'h0000);
		wr(1'h0, 16'h0010);
		saturation_trip_in = 1;
		repeat (6) @(negedge mclk);
		`CHK("sat_early", 1'h0, saturation_fault)
		repeat (3) @(negedge mclk);
		`CHK("sat_short", 1'h1, saturation_fault)
		saturation_trip_in = 0;
		wr(1'h0, 16'h1010);
		repeat (4) @(negedge mclk);
		saturation_trip_in = 1;
		repeat (10) @(negedge mclk);
		`CHK("sat_mid", 1'h0, saturation_fault)
		repeat (3) @(negedge mclk);
		`CHK("sat_long", 1'h1, saturation_fault)
		// detection off with the pin still high
		wr(1'h0, 16'h1000);
		@(negedge mclk);
		`CHK("sat_off", 1'h0, saturation_fault)
		saturation_trip_in = 0;
		// pwm edge restarts blanking; code 1 needs 25 quiet cycles, code 0 only 13
		wr(1'h0, 16'h0100);
		pwm_in = 0;
		repeat (2) @(negedge mclk);
		gate_fault_in = 1;
		repeat (18) @(negedge mclk);
		`CHK("gm_blank", 1'h0, gate_monitor_fault)
		`CHK("pwm_low", 1'h0, pwm_out)
		repeat (12) @(negedge mclk);
		`CHK("gm_on", 1'h1, gate_monitor_fault)
		wr(1'h0, 16'h0180);
		@(negedge mclk);
		`CHK("gm_off", 1'h0, gate_monitor_fault)
		{gate_fault_in, pwm_in} = 2'h1;
	endtask
	initial begin
		{rst_n, cfg_sel, cfg_wr, cfg_wdata, gate_fault_in, saturation_trip_in} = 0;
		{thermal_trip_in, short_trip_in, overcurrent_trip_in} = 3'h0;
		pwm_in = 1;
		repeat (8) @(negedge mclk);
		rst_n = 1;
		`CHK("rst1", 16'h0934, protection_enable_config)
		`CHK("rst2", 16'h7741, desat_turnoff_config)
		t_rw();
		t_modes();
		t_prot();
		t_sat_gm();
		final_report();
	end
	initial begin
		repeat (3000) @(posedge mclk);
		failures++;
		final_report();
	end
endmodule
bind pcr_top pcr_props chk (
	.mclk                     (mclk),
	.rst_n                    (rst_n),
	.cfg_sel                  (cfg_sel),
	.cfg_wr                   (cfg_wr),
	.cfg_wdata                (cfg_wdata),
	.cfg_rdata                (cfg_rdata),
	.protection_enable_config (protection_enable_config),
	.desat_turnoff_config     (desat_turnoff_config),
	.short_fault              (short_fault),
	.overcurrent_fault        (overcurrent_fault),
	.thermal_fault            (thermal_fault),
	.soft_off_req             (soft_off_req),
	.two_level_req            (two_level_req),
	.pwm_muted                (pwm_muted),
	.pwm_out                  (pwm_out)
);
